// File: dda_channel.sv
`timescale 1ns/1ps
module dda_channel
  import dda_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [31:4] cfg_io_base,
  input wire logic [31:0] io_addr,
  input wire logic [3:0] io_be_n,
  input wire logic [31:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  output logic [31:0] io_rdata_r,
  output logic io_ack_r,
  input wire logic xfer_16bit,
  input wire logic address_direction_select,
  input wire logic addr_phase,
  input wire logic xfer_done,
  output logic [31:0] ad_out_r,
  output logic ad_oe_r,
  output logic tc_r,
  output logic active_r
);
  // The decode compares address bits 31:4, so only a sixteen byte window can be served.
  if (DDA_WIN_BYTES != 16) begin : g_win_check
    $error("dda_channel serves a sixteen byte window only");
  end

  // ==========================================================
  // Window decode
  // ==========================================================
  function automatic logic win_hit(input logic [31:0] a, input logic [31:4] b);
    win_hit = (a[31:4] == b);
  endfunction

  logic rd_hit;
  logic wr_hit;
  logic [1:0] idx;
  assign rd_hit = io_rd && win_hit(io_addr, cfg_io_base);
  assign wr_hit = io_wr && win_hit(io_addr, cfg_io_base);
  assign idx = io_addr[3:2];

  // ==========================================================
  // Channel state
  // ==========================================================
  logic [15:0] addr_r;
  logic [15:0] addr_nxt;
  logic [7:0] page_r;
  logic [7:0] page_nxt;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  dda_state_type state_r;
  dda_state_type state_nxt;
  logic tc_nxt;
  logic [15:0] step;
  logic count_wr;
  logic xfer_ok;

  assign step = xfer_16bit ? DDA_STEP16 : DDA_STEP8;
  assign count_wr = wr_hit && (idx == DDA_IDX_COUNT) && (io_be_n[1:0] != 2'h3);
  // A software write in the same cycle as a transfer wins; the transfer is dropped.
  assign xfer_ok = xfer_done && (state_r == DDA_ST_RUN) && !wr_hit;

  always_comb begin
    addr_nxt = addr_r;
    page_nxt = page_r;
    count_nxt = count_r;
    state_nxt = state_r;
    tc_nxt = 1'b0;
    if (wr_hit && idx == DDA_IDX_ADDR) begin
      if (!io_be_n[0]) begin
        addr_nxt[7:0] = io_wdata[7:0];
      end
      if (!io_be_n[1]) begin
        addr_nxt[15:8] = io_wdata[15:8];
      end
      if (!io_be_n[2]) begin
        page_nxt = io_wdata[23:16];
      end
    end
    if (count_wr) begin
      if (!io_be_n[0]) begin
        count_nxt[7:0] = io_wdata[7:0];
      end
      if (!io_be_n[1]) begin
        count_nxt[15:8] = io_wdata[15:8];
      end
      state_nxt = (count_nxt != 16'h0000) ? DDA_ST_RUN : DDA_ST_IDLE;
    end
    // Byte 3 of the first word and all of the third and fourth words fall through untouched.
    if (xfer_ok) begin
      if (address_direction_select) begin
        addr_nxt = addr_r - DDA_ADDR_STEP;
      end else begin
        addr_nxt = addr_r + DDA_ADDR_STEP;
      end
      if (count_r <= step) begin
        count_nxt = 16'h0000;
        state_nxt = DDA_ST_IDLE;
        tc_nxt = 1'b1;
      end else begin
        count_nxt = count_r - step;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      addr_r <= DDA_ADDR_RST;
      page_r <= DDA_PAGE_RST;
      count_r <= DDA_COUNT_RST;
      state_r <= DDA_ST_IDLE;
      tc_r <= 1'b0;
      active_r <= 1'b0;
    end else begin
      addr_r <= addr_nxt;
      page_r <= page_nxt;
      count_r <= count_nxt;
      state_r <= state_nxt;
      tc_r <= tc_nxt;
      active_r <= (state_nxt == DDA_ST_RUN);
    end
  end

  // ==========================================================
  // Register read path
  // ==========================================================
  logic [31:0] rdata_nxt;
  logic ack_nxt;

  always_comb begin
    ack_nxt = rd_hit || wr_hit;
    rdata_nxt = 32'h0000_0000;
    if (rd_hit) begin
      case (idx)
        DDA_IDX_ADDR: begin
          rdata_nxt = {8'h00, page_r, addr_r};
        end
        DDA_IDX_COUNT: begin
          rdata_nxt = {16'h0000, count_r};
        end
        default: begin
          rdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      io_rdata_r <= 32'h0000_0000;
      io_ack_r <= 1'b0;
    end else begin
      io_rdata_r <= rdata_nxt;
      io_ack_r <= ack_nxt;
    end
  end

  // ==========================================================
  // Address phase drive
  // ==========================================================
  logic [31:0] ad_word;
  logic [31:0] ad_nxt;
  logic oe_nxt;

  dda_ad_format u_fmt (
    .cur_addr(addr_r),
    .page(page_r),
    .wide(xfer_16bit),
    .ad_word(ad_word)
  );

  always_comb begin
    oe_nxt = addr_phase && (state_r == DDA_ST_RUN);
    ad_nxt = oe_nxt ? ad_word : 32'h0000_0000;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ad_out_r <= 32'h0000_0000;
      ad_oe_r <= 1'b0;
    end else begin
      ad_out_r <= ad_nxt;
      ad_oe_r <= oe_nxt;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_window_miss: assert property (
    (io_rd || io_wr) && !win_hit(io_addr, cfg_io_base) |=> !io_ack_r)
    else $error("ack outside window");
  chk_rsvd_read_zero: assert property (
    rd_hit && idx[1] |=> io_ack_r && io_rdata_r == 32'h0000_0000)
    else $error("reserved read not zero");
  chk_rsvd_write_none: assert property (
    wr_hit && idx[1] |=> $stable(addr_r) && $stable(page_r) && $stable(count_r)
    && $stable(state_r)) else $error("reserved write had effect");
  chk_addr_readback: assert property (
    rd_hit && idx == DDA_IDX_ADDR |=> io_rdata_r == {8'h00, $past(page_r), $past(addr_r)})
    else $error("address read");
  chk_count_readback: assert property (
    rd_hit && idx == DDA_IDX_COUNT |=> io_rdata_r == {16'h0000, $past(count_r)})
    else $error("count read");
  chk_byte_phase: assert property (
    oe_nxt && !xfer_16bit |=> ad_oe_r && ad_out_r == {8'h00, $past(page_r), $past(addr_r)})
    else $error("byte mode address phase");
  chk_word_phase: assert property (
    oe_nxt && xfer_16bit
    |=> ad_oe_r && ad_out_r == {8'h00, $past(page_r[7:1]), $past(addr_r), 1'b0})
    else $error("word mode address phase");
  chk_count_byte: assert property (
    xfer_ok && !xfer_16bit && count_r > DDA_STEP8 |=> count_r == $past(count_r) - DDA_STEP8)
    else $error("byte count step");
  chk_count_word: assert property (
    xfer_ok && xfer_16bit && count_r > DDA_STEP16 |=> count_r == $past(count_r) - DDA_STEP16)
    else $error("word count step");
  chk_addr_dir: assert property (
    xfer_ok |=> addr_r == ($past(address_direction_select) ?
    $past(addr_r) - DDA_ADDR_STEP : $past(addr_r) + DDA_ADDR_STEP)) else $error("addr step");
  chk_tc_end: assert property (
    xfer_ok && count_r <= step |=> tc_r && !active_r && count_r == 16'h0000 ##1 !tc_r)
    else $error("terminal count");

  cov_byte_run: cover property (count_wr ##[1:20] xfer_ok && !xfer_16bit);
  cov_word_tc: cover property (xfer_ok && xfer_16bit ##1 tc_r);
  cov_phase: cover property (oe_nxt ##1 ad_oe_r);
  cov_down: cover property (xfer_ok && address_direction_select);
endmodule

// File: dda_pkg.sv
package dda_pkg;
  // ==========================================================
  // Channel window layout
  // ==========================================================
  localparam int DDA_WIN_BYTES = 16;
  localparam logic [3:0] DDA_OFS_ADDR = 4'h0;
  localparam logic [3:0] DDA_OFS_PAGE = 4'h2;
  localparam logic [3:0] DDA_OFS_COUNT = 4'h4;
  localparam logic [7:0] DDA_CFG_BASE_OFS = 8'h98;
  localparam logic [1:0] DDA_IDX_ADDR = 2'h0;
  localparam logic [1:0] DDA_IDX_COUNT = 2'h1;
  localparam logic [4:0] DDA_PAGE_BIT = 5'h10;

  // ==========================================================
  // Reset values and steps
  // ==========================================================
  localparam logic [15:0] DDA_ADDR_RST = 16'h0000;
  localparam logic [7:0] DDA_PAGE_RST = 8'h00;
  localparam logic [15:0] DDA_COUNT_RST = 16'h0000;
  localparam logic [15:0] DDA_STEP8 = 16'h0001;
  localparam logic [15:0] DDA_STEP16 = 16'h0002;
  localparam logic [15:0] DDA_ADDR_STEP = 16'h0001;

  typedef enum logic [0:0] {
    DDA_ST_IDLE = 1'b0,
    DDA_ST_RUN = 1'b1
  } dda_state_type;
endpackage

// File: dda_ad_format.sv
`timescale 1ns/1ps
module dda_ad_format
  import dda_pkg::*;
(
  input wire logic [15:0] cur_addr,
  input wire logic [7:0] page,
  input wire logic wide,
  output logic [31:0] ad_word
);
  // ==========================================================
  // Address phase word
  // ==========================================================
  always_comb begin
    if (wide) begin
      // Page bit 0 is dropped because the word address already covers AD16.
      ad_word = {8'h00, page[7:1], cur_addr, 1'b0};
    end else begin
      ad_word = {8'h00, page, cur_addr};
    end
  end
endmodule

// File: dda_dma_master.sv
`timescale 1ns/1ps
module dda_dma_master (
  input wire logic ref_clk,
  input wire logic ad_oe_r,
  input wire logic [31:0] ad_out_r,
  input wire logic tc_r,
  output logic addr_phase,
  output logic xfer_done,
  output logic [31:0] ad_seen,
  output logic tc_seen
);
  // ==========================================================
  // Transfer sequencing
  // ==========================================================
  initial begin
    addr_phase = 1'b0;
    xfer_done = 1'b0;
    ad_seen = 32'h0;
    tc_seen = 1'b0;
  end

  // A nonzero gap plays a slow target; zero puts the data beat right after the address.
  // An undriven bus reads as all ones, so a missing enable cannot pass for a zero address.
  task automatic xfer(input logic [2:0] gap);
    @(negedge ref_clk);
    addr_phase = 1'b1;
    @(negedge ref_clk);
    addr_phase = 1'b0;
    ad_seen = ad_oe_r ? ad_out_r : 32'hffff_ffff;
    repeat (gap) @(negedge ref_clk);
    xfer_done = 1'b1;
    @(negedge ref_clk);
    xfer_done = 1'b0;
    tc_seen = tc_r;
  endtask
endmodule

// File: tb_dda_channel.sv
`timescale 1ns/1ps
module tb_dda_channel;
  import dda_pkg::*;
  logic ref_clk, rst, io_wr, io_rd, xfer_16bit, address_direction_select, io_ack_r;
  logic addr_phase, xfer_done, ad_oe_r, tc_r, active_r, tc_seen;
  logic [31:4] cfg_io_base;
  logic [31:0] io_addr, io_wdata, io_rdata_r, ad_out_r, ad_seen;
  logic [3:0] io_be_n;
  logic [15:0] a, c;
  logic [7:0] p;
  int n_fail, comparisons;

  dda_channel u_dda_channel (.ref_clk(ref_clk), .rst(rst), .cfg_io_base(cfg_io_base),
    .io_addr(io_addr), .io_be_n(io_be_n), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
    .io_rdata_r(io_rdata_r), .io_ack_r(io_ack_r), .xfer_16bit(xfer_16bit),
    .address_direction_select(address_direction_select), .addr_phase(addr_phase),
    .xfer_done(xfer_done), .ad_out_r(ad_out_r), .ad_oe_r(ad_oe_r), .tc_r(tc_r),
    .active_r(active_r));
  dda_dma_master u_dda_dma_master (.ref_clk(ref_clk), .ad_oe_r(ad_oe_r), .ad_out_r(ad_out_r),
    .tc_r(tc_r), .addr_phase(addr_phase), .xfer_done(xfer_done), .ad_seen(ad_seen),
    .tc_seen(tc_seen));

  // ==========================================================
  // Checking helpers
  // ==========================================================
  task automatic end_sim;
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] exp_ad(input logic [15:0] ca, input logic [7:0] pg,
                                         input logic w);
    exp_ad = w ? {8'h00, pg[7:1], ca, 1'b0} : {8'h00, pg, ca};
  endfunction

  // A miss flips the lowest base bit, so the access lands just outside the window.
  task automatic acc(input logic w, input logic miss, input logic [3:0] ofs,
                     input logic [31:0] d, input logic [3:0] be, input logic [31:0] exp);
    @(negedge ref_clk);
    io_addr = {cfg_io_base ^ {27'h0, miss}, ofs};
    io_wdata = d;
    io_be_n = be;
    io_wr = w;
    io_rd = !w;
    @(negedge ref_clk);
    io_wr = 1'b0;
    io_rd = 1'b0;
    chk({31'h0, io_ack_r}, {31'h0, !miss});
    if (!w)
      chk(io_rdata_r, exp);
  endtask

  // ==========================================================
  // Stimulus
  // ==========================================================
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    end_sim();
  end

  initial begin
    {rst, io_wr, io_rd, xfer_16bit, address_direction_select} = 5'h10;
    {io_addr, io_wdata, io_be_n, cfg_io_base} = '0;
    void'($urandom(32'hf1ec));
    cfg_io_base = 28'($urandom);
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    acc(1'b0, 1'b0, 4'h0, 32'h0, 4'h0, 32'h0);
    acc(1'b0, 1'b0, 4'h4, 32'h0, 4'h0, 32'h0);
    acc(1'b1, 1'b1, 4'h0, 32'hffff_ffff, 4'h0, 32'h0);
    acc(1'b0, 1'b1, 4'h0, 32'h0, 4'h0, 32'h0);
    acc(1'b1, 1'b0, 4'hc, 32'hffff_ffff, 4'h0, 32'h0);
    acc(1'b0, 1'b0, 4'hc, 32'h0, 4'h0, 32'h0);
    acc(1'b0, 1'b0, 4'h8, 32'h0, 4'h0, 32'h0);
    acc(1'b0, 1'b0, 4'h0, 32'h0, 4'h0, 32'h0);
    acc(1'b0, 1'b0, 4'h4, 32'h0, 4'h0, 32'h0);
    for (int m = 0; m < 4; m++) begin
      a = (m == 2) ? 16'h0000 : 16'($urandom);
      p = 8'($urandom);
      c = m[0] ? 16'(2 + m) : 16'($urandom_range(1, 4));
      xfer_16bit = m[0];
      address_direction_select = m[1];
      acc(1'b1, 1'b0, 4'h0, {8'h5a, 8'h77, a}, 4'h4, 32'h0);
      acc(1'b1, 1'b0, 4'h0, {8'h00, p, 16'h0}, 4'hb, 32'h0);
      acc(1'b1, 1'b0, 4'h4, {16'hbeef, c}, 4'h0, 32'h0);
      acc(1'b1, 1'b0, m[0] ? 4'hc : 4'h8, 32'hffff_ffff, 4'h0, 32'h0);
      acc(1'b0, 1'b0, 4'h0, 32'h0, 4'h0, {8'h00, p, a});
      acc(1'b0, 1'b0, 4'h4, 32'h0, 4'h0, {16'h0, c});
      chk({31'h0, active_r}, 32'h0000_0001);
      while (c != 16'h0) begin
        u_dda_dma_master.xfer(3'($urandom_range(0, 3)));
        chk(ad_seen, exp_ad(a, p, m[0]));
        a = m[1] ? a - 16'h1 : a + 16'h1;
        c = (c <= (m[0] ? 16'h2 : 16'h1)) ? 16'h0 : c - (m[0] ? 16'h2 : 16'h1);
        chk({31'h0, tc_seen}, {31'h0, c == 16'h0});
        chk({31'h0, active_r}, {31'h0, c != 16'h0});
        acc(1'b0, 1'b0, 4'h0, 32'h0, 4'h0, {8'h00, p, a});
        acc(1'b0, 1'b0, 4'h4, 32'h0, 4'h0, {16'h0, c});
      end
      u_dda_dma_master.xfer(3'h0);
      chk(ad_seen, 32'hffff_ffff);
      chk({31'h0, tc_seen}, 32'h0);
    end
    // ==========================================================
    // Software write meeting a transfer, then reset in mid-run
    // ==========================================================
    c = 16'($urandom_range(3, 9));
    acc(1'b1, 1'b0, 4'h4, {16'h0, c}, 4'h0, 32'h0);
    fork
      u_dda_dma_master.xfer(3'h0);
      begin
        @(negedge ref_clk);
        acc(1'b1, 1'b0, 4'h4, {16'h0, c + 16'h1}, 4'hc, 32'h0);
      end
    join
    chk({31'h0, tc_seen}, 32'h0);
    acc(1'b0, 1'b0, 4'h4, 32'h0, 4'h0, {16'h0, c + 16'h1});
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    chk({31'h0, active_r}, 32'h0);
    acc(1'b0, 1'b0, 4'h0, 32'h0, 4'h0, 32'h0);
    acc(1'b0, 1'b0, 4'h4, 32'h0, 4'h0, 32'h0);
    end_sim();
  end
endmodule
